/* File: src/dag_core.sv */
`timescale 1ns/100ps
module dag_core
  import dag_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // decoder side, one request per cycle
  input wire logic addr_req,
  input wire logic addr_indirect,
  input wire logic addr_is_write,
  input wire logic [dag_pkg::DAG_OFSW-1:0] instr_offset,
  input wire dag_pkg::dag_op_e ptr_op,
  input wire dag_pkg::dag_cmp_e ptr_cmp_kind,
  input wire logic next_sel_load,
  input wire logic [dag_pkg::DAG_SELW-1:0] next_sel,
  input wire logic page_load,
  input wire logic [dag_pkg::DAG_PAGEW-1:0] page_value,
  // data memory address buses, compare flag and selector/page fields
  output logic [dag_pkg::DAG_AW-1:0] rd_addr,
  output logic rd_addr_valid,
  output logic [dag_pkg::DAG_AW-1:0] wr_addr,
  output logic wr_addr_valid,
  output logic cmp_flag,
  output logic [dag_pkg::DAG_SELW-1:0] pointer_select_field,
  output logic [dag_pkg::DAG_SELW-1:0] pointer_select_backup,
  output logic [dag_pkg::DAG_PAGEW-1:0] page_select_field,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import dag_pkg::*;

  dag_arith_if au();

  logic [DAG_AW-1:0] pointer_regs_r [DAG_NPTR];
  logic [DAG_AW-1:0] pointer_regs_nxt [DAG_NPTR];
  logic [DAG_SELW-1:0] sel_r, sel_nxt;
  logic [DAG_SELW-1:0] bak_r, bak_nxt;
  logic [DAG_PAGEW-1:0] page_r, page_nxt;
  logic cmp_r, cmp_nxt;
  logic [DAG_AW-1:0] rd_addr_r, rd_addr_nxt, wr_addr_r, wr_addr_nxt;
  logic rd_v_r, rd_v_nxt, wr_v_r, wr_v_nxt;

  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // readies are flops of their own so every port leaves a register
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;

  logic [DAG_AW-1:0] cur_ptr;
  logic [DAG_AW-1:0] eff_addr;
  logic do_write;
  logic [31:0] merged;

  assign cur_ptr = pointer_regs_r[sel_r];
  // pointer 0 serves as index for add/sub and compare
  assign au.ptr = cur_ptr;
  assign au.index = pointer_regs_r[0];
  assign au.op = ptr_op;
  assign au.cmp_kind = ptr_cmp_kind;

  dag_arith_unit u_arith (
    .au(au)
  );

  // page in the upper nine bits, offset below: 512 pages of 128 words
  always_comb begin
    if (addr_indirect) begin
      eff_addr = cur_ptr;
    end else begin
      eff_addr = {page_r, instr_offset};
    end
  end

  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

  always_comb begin
    merged = wdata_r;
    if (awaddr_r == DAG_REG_CTRL) begin
      merged = 32'h0;
      merged[DAG_CTRL_SEL_LSB +: DAG_SELW] = sel_r;
      merged[DAG_CTRL_PAGE_LSB +: DAG_PAGEW] = page_r;
    end else if ((awaddr_r & DAG_PTR_MASK) == DAG_REG_PTR0) begin
      merged = {16'h0, pointer_regs_r[awaddr_r[4:2]]};
    end
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) begin
        merged[8*b +: 8] = wdata_r[8*b +: 8];
      end
    end
  end

  // datapath next state
  always_comb begin
    for (int i = 0; i < DAG_NPTR; i++) begin
      pointer_regs_nxt[i] = pointer_regs_r[i];
    end
    sel_nxt = sel_r;
    bak_nxt = bak_r;
    page_nxt = page_r;
    cmp_nxt = cmp_r;
    rd_addr_nxt = rd_addr_r;
    wr_addr_nxt = wr_addr_r;
    rd_v_nxt = 1'b0;
    wr_v_nxt = 1'b0;
    // software writes first so decoder actions in the same cycle win
    if (do_write && awaddr_r == DAG_REG_CTRL) begin
      sel_nxt = merged[DAG_CTRL_SEL_LSB +: DAG_SELW];
      page_nxt = merged[DAG_CTRL_PAGE_LSB +: DAG_PAGEW];
      bak_nxt = sel_r;
    end
    if (do_write && (awaddr_r & DAG_PTR_MASK) == DAG_REG_PTR0) begin
      pointer_regs_nxt[awaddr_r[4:2]] = merged[DAG_AW-1:0];
    end
    if (addr_req) begin
      // a new address every cycle, no stall
      if (addr_is_write) begin
        wr_addr_nxt = eff_addr;
        wr_v_nxt = 1'b1;
      end else begin
        rd_addr_nxt = eff_addr;
        rd_v_nxt = 1'b1;
      end
    end
    // post-modify: the address above already used the old pointer
    if (ptr_op == DAG_OP_CMP) begin
      cmp_nxt = au.cmp_true;
    end else if (ptr_op != DAG_OP_NONE) begin
      pointer_regs_nxt[sel_r] = au.result;
    end
    if (page_load) begin
      page_nxt = page_value;
    end
    if (next_sel_load) begin
      sel_nxt = next_sel;
      bak_nxt = sel_r;
    end
  end

  // bus slave next state
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      if (awaddr_r == DAG_REG_CTRL || (awaddr_r & DAG_PTR_MASK) == DAG_REG_PTR0) begin
        bresp_nxt = DAG_RESP_OKAY;
      end else begin
        bresp_nxt = DAG_RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = DAG_RESP_OKAY;
      rdata_nxt = 32'h0;
      if (s_axi_araddr == DAG_REG_CTRL) begin
        rdata_nxt[DAG_CTRL_SEL_LSB +: DAG_SELW] = sel_r;
        rdata_nxt[DAG_CTRL_PAGE_LSB +: DAG_PAGEW] = page_r;
      end else if (s_axi_araddr == DAG_REG_STAT) begin
        rdata_nxt[DAG_STAT_BAK_LSB +: DAG_SELW] = bak_r;
        rdata_nxt[DAG_STAT_CMP_BIT] = cmp_r;
      end else if ((s_axi_araddr & DAG_PTR_MASK) == DAG_REG_PTR0) begin
        rdata_nxt[DAG_AW-1:0] = pointer_regs_r[s_axi_araddr[4:2]];
      end else begin
        rresp_nxt = DAG_RESP_SLVERR;
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    // ready tracks an empty slot one edge ahead, so it stays a plain flop
    awready_nxt = !aw_hold_nxt;
    wready_nxt = !w_hold_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DAG_NPTR; i++) begin
        pointer_regs_r[i] <= 16'h0000;
      end
      sel_r <= 3'h0;
      bak_r <= 3'h0;
      page_r <= 9'h000;
      cmp_r <= 1'b0;
      rd_addr_r <= 16'h0000;
      wr_addr_r <= 16'h0000;
      rd_v_r <= 1'b0;
      wr_v_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'b00;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      pointer_regs_r <= pointer_regs_nxt;
      sel_r <= sel_nxt;
      bak_r <= bak_nxt;
      page_r <= page_nxt;
      cmp_r <= cmp_nxt;
      rd_addr_r <= rd_addr_nxt;
      wr_addr_r <= wr_addr_nxt;
      rd_v_r <= rd_v_nxt;
      wr_v_r <= wr_v_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign rd_addr = rd_addr_r;
  assign rd_addr_valid = rd_v_r;
  assign wr_addr = wr_addr_r;
  assign wr_addr_valid = wr_v_r;
  assign cmp_flag = cmp_r;
  assign pointer_select_field = sel_r;
  assign pointer_select_backup = bak_r;
  assign page_select_field = page_r;
  // ready high only while the slot is empty, also during reset
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule

/* File: src/dag_pkg.sv */
package dag_pkg;
  localparam int unsigned DAG_AW = 16;
  localparam int unsigned DAG_NPTR = 8;
  localparam int unsigned DAG_SELW = 3;
  localparam int unsigned DAG_PAGEW = 9;
  localparam int unsigned DAG_OFSW = 7;
  localparam int unsigned DAG_NPAGE = 512;
  localparam int unsigned DAG_PAGE_WORDS = 128;
  localparam logic [DAG_PAGEW-1:0] DAG_LAST_PAGE = 9'h1ff;
  localparam logic [DAG_AW-1:0] DAG_LAST_PAGE_BASE = 16'hff80;

  // axi-lite map, 32-bit words
  localparam logic [7:0] DAG_REG_CTRL = 8'h00;
  localparam logic [7:0] DAG_REG_STAT = 8'h04;
  localparam logic [7:0] DAG_REG_PTR0 = 8'h20;
  localparam logic [7:0] DAG_PTR_MASK = 8'he0;
  localparam int unsigned DAG_CTRL_SEL_LSB = 0;
  localparam int unsigned DAG_CTRL_PAGE_LSB = 16;
  localparam int unsigned DAG_STAT_BAK_LSB = 0;
  localparam int unsigned DAG_STAT_CMP_BIT = 8;
  localparam logic [1:0] DAG_RESP_OKAY = 2'b00;
  localparam logic [1:0] DAG_RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    DAG_OP_NONE,
    DAG_OP_INC,
    DAG_OP_DEC,
    DAG_OP_ADD,
    DAG_OP_SUB,
    DAG_OP_ADD_REV,
    DAG_OP_SUB_REV,
    DAG_OP_CMP
  } dag_op_e;

  typedef enum logic [1:0] {
    DAG_CMP_EQ,
    DAG_CMP_LT,
    DAG_CMP_GT,
    DAG_CMP_NE
  } dag_cmp_e;
endpackage

/* File: src/dag_arith_if.sv */
`timescale 1ns/100ps
interface dag_arith_if;
  import dag_pkg::*;
  logic [DAG_AW-1:0] ptr;
  logic [DAG_AW-1:0] index;
  dag_op_e op;
  dag_cmp_e cmp_kind;
  logic [DAG_AW-1:0] result;
  logic cmp_true;
  modport core (output ptr, output index, output op, output cmp_kind, input result, input cmp_true);
  modport unit (input ptr, input index, input op, input cmp_kind, output result, output cmp_true);
endinterface

/* File: src/dag_arith_unit.sv */
`timescale 1ns/100ps
module dag_arith_unit
  import dag_pkg::*;
(
  dag_arith_if.unit au
);
  logic [DAG_AW-1:0] ptr_rev;
  logic [DAG_AW-1:0] idx_rev;
  logic [DAG_AW-1:0] sum_rev;
  logic [DAG_AW-1:0] dif_rev;
  logic [DAG_AW-1:0] sum_rev_back;
  logic [DAG_AW-1:0] dif_rev_back;

  // carry runs msb to lsb: reverse, add, reverse back
  genvar g;
  generate
    for (g = 0; g < DAG_AW; g++) begin : g_rev
      assign ptr_rev[g] = au.ptr[DAG_AW-1-g];
      assign idx_rev[g] = au.index[DAG_AW-1-g];
      assign sum_rev_back[g] = sum_rev[DAG_AW-1-g];
      assign dif_rev_back[g] = dif_rev[DAG_AW-1-g];
    end
  endgenerate

  always_comb begin
    sum_rev = ptr_rev + idx_rev;
    dif_rev = ptr_rev - idx_rev;
    au.result = au.ptr;
    case (au.op)
      DAG_OP_INC: au.result = au.ptr + 16'h0001;
      DAG_OP_DEC: au.result = au.ptr - 16'h0001;
      DAG_OP_ADD: au.result = au.ptr + au.index;
      DAG_OP_SUB: au.result = au.ptr - au.index;
      DAG_OP_ADD_REV: au.result = sum_rev_back;
      DAG_OP_SUB_REV: au.result = dif_rev_back;
      default: au.result = au.ptr;
    endcase
  end

  always_comb begin
    case (au.cmp_kind)
      DAG_CMP_EQ: au.cmp_true = (au.ptr == au.index);
      DAG_CMP_LT: au.cmp_true = (au.ptr < au.index);
      DAG_CMP_GT: au.cmp_true = (au.ptr > au.index);
      default: au.cmp_true = (au.ptr != au.index);
    endcase
  end
endmodule

/* File: tb/dag_chk.sv */
`timescale 1ns/100ps
module dag_chk
  import dag_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // decoder side
  input wire logic addr_req,
  input wire logic addr_indirect,
  input wire logic addr_is_write,
  input wire logic [6:0] instr_offset,
  input wire logic next_sel_load,
  input wire logic [2:0] next_sel,
  input wire logic page_load,
  input wire logic [8:0] page_value,
  // address buses, fields and write response handshake
  input wire logic [15:0] rd_addr,
  input wire logic rd_addr_valid,
  input wire logic wr_addr_valid,
  input wire logic [2:0] pointer_select_field,
  input wire logic [2:0] pointer_select_backup,
  input wire logic [8:0] page_select_field,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd;
    addr_req && !addr_is_write;
  endsequence
  AST_RD: assert property (s_rd |=> rd_addr_valid && !wr_addr_valid)
    else $error("read address missing");
  AST_WR: assert property (addr_req && addr_is_write |=> wr_addr_valid && !rd_addr_valid)
    else $error("write address missing");
  AST_IDLE: assert property (!addr_req |=> !rd_addr_valid && !wr_addr_valid)
    else $error("address without request");
  AST_HOLD: assert property (!(addr_req && !addr_is_write) |=> $stable(rd_addr))
    else $error("read address moved");
  AST_DIR: assert property (s_rd ##0 !addr_indirect
    |=> rd_addr == {$past(page_select_field), $past(instr_offset)}) else $error("direct address wrong");
  AST_SEL: assert property (next_sel_load
    |=> pointer_select_field == $past(next_sel) && pointer_select_backup == $past(pointer_select_field))
    else $error("selector load wrong");
  AST_PAGE: assert property (page_load |=> page_select_field == $past(page_value))
    else $error("page load wrong");
  AST_BRESP: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
bind dag_core dag_chk u_chk (.*);

/* File: tb/dag_mem_model.sv */
`timescale 1ns/100ps
module dag_mem_model (
  // clock and address valid strobes
  input wire logic aclk,
  input wire logic rd_addr_valid,
  input wire logic wr_addr_valid,
  // accesses served
  output int unsigned access_cnt
);
  // one access per strobe; memory never stalls
  always_ff @(posedge aclk) begin
    access_cnt <= access_cnt + 32'(rd_addr_valid) + 32'(wr_addr_valid);
  end
endmodule

/* File: tb/dag_core_tb.sv */
`timescale 1ns/100ps
module dag_core_tb;
  import dag_pkg::*;
  logic aclk, aresetn, addr_req, addr_indirect, addr_is_write, next_sel_load, page_load;
  logic rd_addr_valid, wr_addr_valid, cmp_flag, pend, pw;
  logic [6:0] instr_offset;
  logic [2:0] next_sel, pointer_select_field, pointer_select_backup, prev;
  logic [8:0] page_value, page_select_field;
  logic [15:0] rd_addr, wr_addr, pa;
  dag_op_e ptr_op;
  dag_cmp_e ptr_cmp_kind;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_total, cmp_count, b_lag;
  int unsigned acc;

  dag_core dut (.*);
  dag_mem_model u_mem (.aclk, .rd_addr_valid, .wr_addr_valid, .access_cnt(acc));

  task automatic stop_test;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // b_lag edges pass before bready rises, so a pending response must hold
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (b_lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == b_lag) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r, "bresp");
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d, "rdata");
    chk(s_axi_rresp, r, "rresp");
  endtask

  // result of a request is judged at the edge that takes the next one
  task automatic flush;
    if (pend) begin
      chk({rd_addr_valid, wr_addr_valid}, pw ? 2'b01 : 2'b10, "strobe");
      chk(pw ? wr_addr : rd_addr, pa, "addr");
    end
    pend = 1'b0;
  endtask

  task automatic issue(input logic ind, input logic wr, input dag_op_e op, input logic [6:0] o, input logic [15:0] e);
    addr_req <= 1'b1;
    addr_indirect <= ind;
    addr_is_write <= wr;
    ptr_op <= op;
    instr_offset <= o;
    @(posedge aclk);
    flush();
    pend = 1'b1;
    pw = wr;
    pa = e;
  endtask

  // extra edge so the next issue never re-drives addr_req in this step
  task automatic idle;
    addr_req <= 1'b0;
    ptr_op <= DAG_OP_NONE;
    @(posedge aclk);
    flush();
    @(posedge aclk);
  endtask

  task automatic set_sel(input logic [2:0] n);
    next_sel_load <= 1'b1;
    next_sel <= n;
    @(posedge aclk);
    next_sel_load <= 1'b0;
    @(posedge aclk);
    chk(pointer_select_field, n, "sel");
    chk(pointer_select_backup, prev, "bak");
    prev = n;
  endtask

  task automatic set_page(input logic [8:0] p);
    page_load <= 1'b1;
    page_value <= p;
    @(posedge aclk);
    page_load <= 1'b0;
    @(posedge aclk);
    chk(page_select_field, p, "page");
  endtask

  task automatic t_reset;
    chk({pointer_select_field, pointer_select_backup, page_select_field}, 0, "rst");
    for (int i = 0; i < 8; i++) axi_rd(DAG_REG_PTR0 + 8'(4*i), 0, DAG_RESP_OKAY);
  endtask

  task automatic t_select;
    for (int i = 0; i < 8; i++) begin
      axi_wr(DAG_REG_PTR0 + 8'(4*i), 32'hbeef0000 | 32'(16'h1111 * i), DAG_RESP_OKAY);
      axi_rd(DAG_REG_PTR0 + 8'(4*i), 32'(16'h1111 * i), DAG_RESP_OKAY);
    end
    for (int i = 0; i < 8; i++) begin
      set_sel(3'(i));
      issue(1'b1, 1'b0, DAG_OP_NONE, 7'h00, 16'(16'h1111 * i));
      idle();
    end
  endtask

  task automatic t_bus;
    axi_wr(DAG_REG_CTRL, 32'h0003_0002, DAG_RESP_OKAY);
    prev = 3'h2;
    axi_rd(DAG_REG_CTRL, 32'h0003_0002, DAG_RESP_OKAY);
    axi_rd(DAG_REG_STAT, 32'h0000_0007, DAG_RESP_OKAY);
    b_lag = 4;
    axi_wr(DAG_REG_STAT, 32'h0000_0005, DAG_RESP_SLVERR);
    b_lag = 0;
    s_axi_wstrb <= 4'h2;
    axi_wr(DAG_REG_PTR0 + 8'h8, 32'h0000_ab00, DAG_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axi_rd(DAG_REG_PTR0 + 8'h8, 32'h0000_ab22, DAG_RESP_OKAY);
    axi_rd(8'h10, 32'h0, DAG_RESP_SLVERR);
    issue(1'b0, 1'b0, DAG_OP_NONE, 7'h05, 16'h0185);
    idle();
    set_page(9'h1ff);
    issue(1'b0, 1'b0, DAG_OP_NONE, 7'h7f, 16'hffff);
    issue(1'b0, 1'b1, DAG_OP_NONE, 7'h00, 16'hff80);
    idle();
  endtask

  task automatic t_arith;
    int unsigned a0;
    set_sel(3'h1);
    axi_wr(DAG_REG_PTR0, 32'h4, DAG_RESP_OKAY);
    axi_wr(DAG_REG_PTR0 + 8'h4, 32'h10, DAG_RESP_OKAY);
    a0 = acc;
    issue(1'b1, 1'b0, DAG_OP_INC, 7'h0, 16'h0010);
    issue(1'b1, 1'b0, DAG_OP_DEC, 7'h0, 16'h0011);
    issue(1'b1, 1'b1, DAG_OP_ADD, 7'h0, 16'h0010);
    issue(1'b1, 1'b0, DAG_OP_SUB, 7'h0, 16'h0014);
    issue(1'b1, 1'b0, DAG_OP_NONE, 7'h0, 16'h0010);
    idle();
    chk(acc - a0, 5, "count");
    for (int k = 0; k < 4; k++) begin
      ptr_cmp_kind <= dag_cmp_e'(k);
      issue(1'b1, 1'b0, DAG_OP_CMP, 7'h0, 16'h0010);
      idle();
      chk(cmp_flag, 1'(4'b1100 >> k), "cmp");
    end
    axi_wr(DAG_REG_PTR0, 32'h8000, DAG_RESP_OKAY);
    axi_wr(DAG_REG_PTR0 + 8'h4, 32'h0, DAG_RESP_OKAY);
    issue(1'b1, 1'b0, DAG_OP_ADD_REV, 7'h0, 16'h0000);
    issue(1'b1, 1'b0, DAG_OP_ADD_REV, 7'h0, 16'h8000);
    issue(1'b1, 1'b0, DAG_OP_SUB_REV, 7'h0, 16'h4000);
    issue(1'b1, 1'b0, DAG_OP_NONE, 7'h0, 16'h8000);
    idle();
  endtask

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  initial begin
    aresetn = 1'b0;
    {addr_req, addr_indirect, addr_is_write, next_sel_load, page_load, pend} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {instr_offset, next_sel, page_value, s_axi_awaddr, s_axi_araddr, s_axi_wdata, prev} = '0;
    ptr_op = DAG_OP_NONE;
    ptr_cmp_kind = DAG_CMP_EQ;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_select();
    t_bus();
    t_arith();
    stop_test();
  end
endmodule
